// ===== pec_pkg.sv
package pec_pkg;

  // widths of the event path
  localparam int PEC_PIPES = 2;
  localparam int PEC_SEL_W = 6;
  localparam int PEC_IDX_W = 3;
  localparam int PEC_CNT_W = 40;
  localparam int PEC_LINE_W = 27;
  localparam int PEC_BEAT_W = 3;

  // number of event codes handled by this block
  localparam int PEC_NUM_EVENTS = 6;
  localparam logic [PEC_SEL_W-1:0] PEC_NUM_EVENTS_SEL = 6'h06;

  // event codes as written into the event-select fields
  localparam logic [PEC_SEL_W-1:0] PEC_EV_DATA_READ = 6'h00;
  localparam logic [PEC_SEL_W-1:0] PEC_EV_DATA_WRITE = 6'h01;
  localparam logic [PEC_SEL_W-1:0] PEC_EV_XLAT_MISS = 6'h02;
  localparam logic [PEC_SEL_W-1:0] PEC_EV_READ_MISS = 6'h03;
  localparam logic [PEC_SEL_W-1:0] PEC_EV_WRITE_MISS = 6'h04;
  localparam logic [PEC_SEL_W-1:0] PEC_EV_WR_HIT_OWNED = 6'h05;

  // per-counter permission masks, one bit per event code
  localparam logic [PEC_NUM_EVENTS-1:0] PEC_CTR0_ALLOWED = 6'h3f;
  localparam logic [PEC_NUM_EVENTS-1:0] PEC_CTR1_ALLOWED = 6'h3f;

  // burst line fill: four burst-ready beats, numbered 0..3
  localparam logic [PEC_BEAT_W-1:0] PEC_BEAT_NONE = 3'h0;
  localparam logic [PEC_BEAT_W-1:0] PEC_BEAT_LAST = 3'h3;
  localparam logic [PEC_BEAT_W-1:0] PEC_BEAT_ONE = 3'h1;

  localparam logic [PEC_CNT_W-1:0] PEC_CNT_RESET = 40'h00_0000_0000;

  // events per clock on one code, 0..2
  typedef logic [1:0] pec_inc_t;

endpackage

// ===== pec_evt_if.sv
`timescale 1ns/1ps
interface pec_evt_if;
  import pec_pkg::*;
  // per-code event count seen this clock
  pec_inc_t ev_cnt [PEC_NUM_EVENTS];
  modport src (output ev_cnt);
  modport cnt (input ev_cnt);
endinterface

// ===== pec_counter.sv
`timescale 1ns/1ps
module pec_counter
  import pec_pkg::*;
#(
  parameter logic [PEC_NUM_EVENTS-1:0] ALLOWED = PEC_CTR0_ALLOWED
) (
  input wire logic mclk,
  input wire logic reset_n,
  pec_evt_if.cnt evt,
  input wire logic [PEC_SEL_W-1:0] event_select,
  output logic [PEC_CNT_W-1:0] value_q
);

  logic sel_ok;
  pec_inc_t inc;
  logic [PEC_CNT_W-1:0] value_d;

  // codes outside the table or barred for this counter add nothing
  always_comb begin
    sel_ok = 1'b0;
    inc = 2'h0;
    if (event_select < PEC_NUM_EVENTS_SEL) begin
      sel_ok = ALLOWED[event_select[PEC_IDX_W-1:0]];
    end
    if (sel_ok) begin
      inc = evt.ev_cnt[event_select[PEC_IDX_W-1:0]];
    end
  end

  // plain binary add; carry out is dropped so the count wraps
  assign value_d = value_q + PEC_CNT_W'(inc);

  // accumulate every clock
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      value_q <= PEC_CNT_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  counter_accum_a: assert property ($past(reset_n) |-> value_q == $past(value_q) + PEC_CNT_W'($past(inc)))
    else $error("counter did not add the selected increment");
  counter_sel_a: assert property (event_select >= PEC_NUM_EVENTS_SEL |=> value_q == $past(value_q))
    else $error("unsupported code changed the counter");
  counter_wrap_c: cover property (value_q == '1 ##1 value_q != '1);

endmodule

// ===== pec_core.sv
`timescale 1ns/1ps
module pec_core
  import pec_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [PEC_SEL_W-1:0] counter0_event_select,
  input wire logic [PEC_SEL_W-1:0] counter1_event_select,
  input wire logic [PEC_PIPES-1:0] pipe_rd_valid,
  input wire logic [PEC_PIPES-1:0] pipe_wr_valid,
  input wire logic [PEC_PIPES-1:0] pipe_tlb_walk,
  input wire logic [PEC_PIPES-1:0] pipe_io_space,
  input wire logic [PEC_PIPES-1:0] pipe_dc_hit,
  input wire logic [PEC_PIPES-1:0] pipe_cacheable,
  input wire logic [PEC_PIPES-1:0] pipe_line_owned,
  input wire logic [PEC_LINE_W-1:0] pipe_line_addr [PEC_PIPES],
  input wire logic xlat_miss_event,
  input wire logic burst_ready_n,
  input wire logic ext_wbuf_empty_n,
  output logic [PEC_CNT_W-1:0] counter0_value_q,
  output logic [PEC_CNT_W-1:0] counter1_value_q,
  output logic wr_hold_q,
  output logic fill_active_q
);

  pec_evt_if evt ();

  // pin synchronisers; first stage feeds only the second
  logic burst_ready_n_meta_q;
  logic burst_ready_n_n_q;
  logic ext_wbuf_empty_n_meta_q;
  logic ext_wbuf_empty_n_n_q;

  // line fill tracker
  logic [PEC_LINE_W-1:0] fill_line_q;
  logic [PEC_BEAT_W-1:0] beats_q;

  // qualified per-pipe accesses
  logic [PEC_PIPES-1:0] mem_ok;
  logic [PEC_PIPES-1:0] rd_ok;
  logic [PEC_PIPES-1:0] wr_ok;
  logic [PEC_PIPES-1:0] same_fill;
  logic [PEC_PIPES-1:0] rd_miss;
  logic [PEC_PIPES-1:0] wr_miss;
  logic [PEC_PIPES-1:0] wr_own;
  logic [PEC_PIPES-1:0] fill_start;
  logic burst_ready_n_beat;
  logic [PEC_LINE_W-1:0] start_line;

  // both pins are asynchronous to mclk; two stages before use
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      burst_ready_n_meta_q <= 1'b1;
      burst_ready_n_n_q <= 1'b1;
    end else begin
      burst_ready_n_meta_q <= burst_ready_n;
      burst_ready_n_n_q <= burst_ready_n_meta_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ext_wbuf_empty_n_meta_q <= 1'b1;
      ext_wbuf_empty_n_n_q <= 1'b1;
    end else begin
      ext_wbuf_empty_n_meta_q <= ext_wbuf_empty_n;
      ext_wbuf_empty_n_n_q <= ext_wbuf_empty_n_meta_q;
    end
  end

  assign burst_ready_n_beat = ~burst_ready_n_n_q; // one beat per low clock

  // page walks and I/O never reach the memory events
  assign mem_ok = ~pipe_tlb_walk & ~pipe_io_space;
  assign rd_ok = pipe_rd_valid & mem_ok;
  assign wr_ok = pipe_wr_valid & mem_ok;

  // a read of a line already under fill and past its first beat is not a new miss
  always_comb begin
    for (int i = 0; i < PEC_PIPES; i++) begin
      same_fill[i] = fill_active_q && (beats_q != PEC_BEAT_NONE)
                     && (pipe_line_addr[i] == fill_line_q);
    end
  end

  assign rd_miss = rd_ok & ~pipe_dc_hit & ~same_fill;
  assign wr_miss = wr_ok & ~pipe_dc_hit;
  assign wr_own = wr_ok & pipe_dc_hit & pipe_line_owned;

  // only cacheable read misses burst-fill; pipe 0 wins a tie
  assign fill_start = rd_miss & pipe_cacheable;
  assign start_line = fill_start[0] ? pipe_line_addr[0] : pipe_line_addr[1];

  // per-code counts; each pipe slot adds one, so up to two a clock; translation miss at most one
  assign evt.ev_cnt[PEC_EV_DATA_READ[PEC_IDX_W-1:0]] =
    {1'b0, rd_ok[0]} + {1'b0, rd_ok[1]};
  assign evt.ev_cnt[PEC_EV_DATA_WRITE[PEC_IDX_W-1:0]] =
    {1'b0, wr_ok[0]} + {1'b0, wr_ok[1]};
  assign evt.ev_cnt[PEC_EV_XLAT_MISS[PEC_IDX_W-1:0]] = {1'b0, xlat_miss_event};
  assign evt.ev_cnt[PEC_EV_READ_MISS[PEC_IDX_W-1:0]] =
    {1'b0, rd_miss[0]} + {1'b0, rd_miss[1]};
  assign evt.ev_cnt[PEC_EV_WRITE_MISS[PEC_IDX_W-1:0]] =
    {1'b0, wr_miss[0]} + {1'b0, wr_miss[1]};
  assign evt.ev_cnt[PEC_EV_WR_HIT_OWNED[PEC_IDX_W-1:0]] =
    {1'b0, wr_own[0]} + {1'b0, wr_own[1]};

  // one fill tracked at a time; beats before a fill starts are ignored
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fill_active_q <= 1'b0;
      beats_q <= PEC_BEAT_NONE;
    end else if (!fill_active_q) begin
      fill_active_q <= |fill_start;
      beats_q <= PEC_BEAT_NONE;
    end else if (burst_ready_n_beat) begin
      if (beats_q == PEC_BEAT_LAST) begin
        fill_active_q <= 1'b0;
        beats_q <= PEC_BEAT_NONE;
      end else begin
        beats_q <= beats_q + PEC_BEAT_ONE;
      end
    end
  end

  // line address captured at the miss that opens the fill
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fill_line_q <= '0;
    end else if (!fill_active_q && |fill_start) begin
      fill_line_q <= start_line;
    end
  end

  // owned-line write hit while the external buffer is not empty
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_hold_q <= 1'b0;
    end else begin
      wr_hold_q <= (|wr_own) & ext_wbuf_empty_n_n_q;
    end
  end

  pec_counter #(
    .ALLOWED(PEC_CTR0_ALLOWED)
  ) u_ctr0 (
    .mclk(mclk),
    .reset_n(reset_n),
    .evt(evt.cnt),
    .event_select(counter0_event_select),
    .value_q(counter0_value_q)
  );

  pec_counter #(
    .ALLOWED(PEC_CTR1_ALLOWED)
  ) u_ctr1 (
    .mclk(mclk),
    .reset_n(reset_n),
    .evt(evt.cnt),
    .event_select(counter1_event_select),
    .value_q(counter1_value_q)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // checks of each code at counter or event level, then the hold flag and fill end
  dual_read_a: assert property (
    counter0_event_select == PEC_EV_DATA_READ && pipe_rd_valid == 2'h3 && mem_ok == 2'h3
    |=> counter0_value_q == $past(counter0_value_q) + 40'h00_0000_0002)
    else $error("two reads in one clock not added as two");
  walk_read_a: assert property (
    counter1_event_select == PEC_EV_DATA_READ && (pipe_tlb_walk | pipe_io_space) == 2'h3
    |=> counter1_value_q == $past(counter1_value_q))
    else $error("walk or io read was counted");
  write_count_a: assert property (
    counter0_event_select == PEC_EV_DATA_WRITE && pipe_wr_valid == 2'h0
    |=> counter0_value_q == $past(counter0_value_q))
    else $error("write counter moved without writes");
  xlat_miss_a: assert property (
    counter1_event_select == PEC_EV_XLAT_MISS && xlat_miss_event
    |=> counter1_value_q == $past(counter1_value_q) + 40'h00_0000_0001)
    else $error("translation miss not counted");
  miss_suppress_a: assert property (
    fill_active_q && beats_q != PEC_BEAT_NONE && pipe_line_addr[0] == fill_line_q
    |-> !rd_miss[0])
    else $error("read to filling line counted again");
  miss_excl_a: assert property (
    (pipe_tlb_walk | pipe_io_space) == 2'h3
    |-> evt.ev_cnt[PEC_EV_READ_MISS[PEC_IDX_W-1:0]] == 2'h0
        && evt.ev_cnt[PEC_EV_WRITE_MISS[PEC_IDX_W-1:0]] == 2'h0)
    else $error("walk or io access counted as miss");
  wmiss_hit_a: assert property (
    pipe_dc_hit == 2'h3 |-> evt.ev_cnt[PEC_EV_WRITE_MISS[PEC_IDX_W-1:0]] == 2'h0)
    else $error("write hit counted as write miss");
  own_hit_a: assert property (
    evt.ev_cnt[PEC_EV_WR_HIT_OWNED[PEC_IDX_W-1:0]] != 2'h0 |-> |(pipe_dc_hit & pipe_line_owned))
    else $error("owned hit without hit on owned line");
  hold_flag_a: assert property ((|wr_own) && ext_wbuf_empty_n_n_q |=> wr_hold_q)
    else $error("owned write hit not held while buffer busy");
  fill_end_a: assert property (
    fill_active_q && beats_q == PEC_BEAT_LAST && burst_ready_n_beat |=> !fill_active_q)
    else $error("fill did not close at fourth beat");

  // two events in one clock on write, owned hit and read miss; write miss with none
  dual_write_a: assert property (
    counter1_event_select == PEC_EV_DATA_WRITE && wr_ok == 2'h3
    |=> counter1_value_q == $past(counter1_value_q) + 40'h00_0000_0002)
    else $error("two writes in one clock not added as two");
  dual_owned_a: assert property (
    counter0_event_select == PEC_EV_WR_HIT_OWNED && wr_own == 2'h3
    |=> counter0_value_q == $past(counter0_value_q) + 40'h00_0000_0002)
    else $error("two owned hits in one clock not added as two");
  rmiss_ctr_a: assert property (
    counter0_event_select == PEC_EV_READ_MISS && rd_miss == 2'h3
    |=> counter0_value_q == $past(counter0_value_q) + 40'h00_0000_0002)
    else $error("two read misses in one clock not added as two");
  wmiss_ctr_a: assert property (
    counter1_event_select == PEC_EV_WRITE_MISS && wr_miss == 2'h0
    |=> counter1_value_q == $past(counter1_value_q))
    else $error("write miss counter moved without misses");

  // per-code event counts against the qualified pipe inputs
  rd_count_a: assert property (
    evt.ev_cnt[PEC_EV_DATA_READ[PEC_IDX_W-1:0]] == $countones(pipe_rd_valid & ~pipe_tlb_walk & ~pipe_io_space))
    else $error("read events differ from qualified reads");
  wr_count_a: assert property (
    evt.ev_cnt[PEC_EV_DATA_WRITE[PEC_IDX_W-1:0]] == $countones(pipe_wr_valid & ~pipe_tlb_walk & ~pipe_io_space))
    else $error("write events differ from qualified writes");
  wmiss_count_a: assert property (
    evt.ev_cnt[PEC_EV_WRITE_MISS[PEC_IDX_W-1:0]]
    == $countones(pipe_wr_valid & ~pipe_dc_hit & ~pipe_tlb_walk & ~pipe_io_space))
    else $error("write miss events differ from qualified misses");
  own_count_a: assert property (
    evt.ev_cnt[PEC_EV_WR_HIT_OWNED[PEC_IDX_W-1:0]]
    == $countones(pipe_wr_valid & pipe_dc_hit & pipe_line_owned & ~pipe_tlb_walk & ~pipe_io_space))
    else $error("owned hit events differ from qualified hits");
  xlat_count_a: assert property (
    evt.ev_cnt[PEC_EV_XLAT_MISS[PEC_IDX_W-1:0]] == {1'b0, xlat_miss_event})
    else $error("translation miss event count wrong");
  rmiss_hit_a: assert property (
    pipe_dc_hit == 2'h3 |-> evt.ev_cnt[PEC_EV_READ_MISS[PEC_IDX_W-1:0]] == 2'h0)
    else $error("read hit counted as read miss");
  rmiss_plain_a: assert property (
    !fill_active_q |-> evt.ev_cnt[PEC_EV_READ_MISS[PEC_IDX_W-1:0]]
    == $countones(pipe_rd_valid & ~pipe_dc_hit & ~pipe_tlb_walk & ~pipe_io_space))
    else $error("read miss events differ while no fill is tracked");

  // fill tracker bookkeeping, one beat at a time
  fill_open_a: assert property (
    !fill_active_q && (|fill_start)
    |=> fill_active_q && beats_q == PEC_BEAT_NONE && fill_line_q == $past(start_line))
    else $error("cacheable miss did not open a fill");
  fill_idle_a: assert property (!fill_active_q && !(|fill_start) |=> !fill_active_q)
    else $error("fill opened without a cacheable miss");
  beat_ignore_a: assert property (!fill_active_q |=> beats_q == PEC_BEAT_NONE)
    else $error("beats counted while no fill tracked");
  beat_step_a: assert property (
    fill_active_q && burst_ready_n_beat && beats_q != PEC_BEAT_LAST
    |=> fill_active_q && beats_q == $past(beats_q) + PEC_BEAT_ONE)
    else $error("burst beat not counted");
  beat_wait_a: assert property (
    fill_active_q && !burst_ready_n_beat
    |=> fill_active_q && beats_q == $past(beats_q) && fill_line_q == $past(fill_line_q))
    else $error("fill state moved without a beat");
  fill_single_a: assert property (
    fill_active_q && (|fill_start) |=> fill_line_q == $past(fill_line_q))
    else $error("second fill replaced the tracked line");

  // the window hides only the tracked line, and only after its first beat
  early_miss_a: assert property (
    fill_active_q && beats_q == PEC_BEAT_NONE && rd_ok[0] && !pipe_dc_hit[0] |-> rd_miss[0])
    else $error("miss before first beat was hidden");
  other_line_a: assert property (
    fill_active_q && pipe_line_addr[1] != fill_line_q && rd_ok[1] && !pipe_dc_hit[1] |-> rd_miss[1])
    else $error("miss to another line was hidden");

  // synchroniser stages and the stall flag
  burst_ready_n_sync_a: assert property ($past(reset_n) |-> burst_ready_n_n_q == $past(burst_ready_n_meta_q))
    else $error("burst ready synchroniser skipped a stage");
  ext_wbuf_empty_n_sync_a: assert property ($past(reset_n) |-> ext_wbuf_empty_n_n_q == $past(ext_wbuf_empty_n_meta_q))
    else $error("write buffer synchroniser skipped a stage");
  hold_clear_a: assert property (!((|wr_own) && ext_wbuf_empty_n_n_q) |=> !wr_hold_q)
    else $error("write hold raised without owned hit and busy buffer");

  fill_seen_c: cover property (!fill_active_q ##1 fill_active_q ##[1:20] !fill_active_q);
  dual_read_c: cover property (rd_ok == 2'h3);
  owned_hold_c: cover property (wr_hold_q);
  suppress_c: cover property (|(rd_ok & ~pipe_dc_hit & same_fill));

endmodule

// ===== perf_event_counter_select_tb_top.sv
`timescale 1ns/1ps
module perf_event_counter_select_tb_top;
  import pec_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [PEC_SEL_W-1:0] sel0 = 6'h00, sel1 = 6'h00;
  logic [PEC_PIPES-1:0] rd = 2'h0, wr = 2'h0, walk = 2'h0, io = 2'h0, hit = 2'h0, cach = 2'h0, own = 2'h0;
  logic [PEC_LINE_W-1:0] addr [PEC_PIPES];
  logic xlat = 1'b0, burst_ready_n_n = 1'b1, wbuf_n = 1'b0, wbuf_last = 1'b0, sup = 1'b0;
  logic [PEC_CNT_W-1:0] c0, c1;
  logic [PEC_CNT_W-1:0] exp0 = '0, exp1 = '0;
  logic hold, fill, exp_hold;
  int bad_count = 0, samples_checked = 0, cycles = 0, wb_stable = 0, seed = 32'h5ac7;

  pec_core dut (.mclk(mclk), .reset_n(reset_n), .counter0_event_select(sel0), .counter1_event_select(sel1),
    .pipe_rd_valid(rd), .pipe_wr_valid(wr), .pipe_tlb_walk(walk), .pipe_io_space(io), .pipe_dc_hit(hit),
    .pipe_cacheable(cach), .pipe_line_owned(own), .pipe_line_addr(addr), .xlat_miss_event(xlat),
    .burst_ready_n(burst_ready_n_n), .ext_wbuf_empty_n(wbuf_n), .counter0_value_q(c0), .counter1_value_q(c1),
    .wr_hold_q(hold), .fill_active_q(fill));

  always #2.5 mclk = ~mclk;

  // events of one code this clock; s marks the pipe0 read that a live fill hides
  function automatic logic [PEC_CNT_W-1:0] ev_inc(input logic [PEC_SEL_W-1:0] code, input logic s);
    logic [PEC_CNT_W-1:0] n;
    logic b;
    n = '0;
    for (int p = 0; p < PEC_PIPES; p++) begin
      case (code)
        PEC_EV_DATA_READ: b = rd[p] & ~walk[p] & ~io[p];
        PEC_EV_DATA_WRITE: b = wr[p] & ~walk[p] & ~io[p];
        PEC_EV_XLAT_MISS: b = (p == 0) & xlat;
        PEC_EV_READ_MISS: b = rd[p] & ~hit[p] & ~walk[p] & ~io[p] & ~(s & (p == 0));
        PEC_EV_WRITE_MISS: b = wr[p] & ~hit[p] & ~walk[p] & ~io[p];
        PEC_EV_WR_HIT_OWNED: b = wr[p] & hit[p] & own[p] & ~walk[p] & ~io[p];
        default: b = 1'b0;
      endcase
      n = n + PEC_CNT_W'(b);
    end
    return n;
  endfunction

  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s mismatch", $time, msg);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reference counters see the same pre-edge inputs as the design
  always @(posedge mclk) begin
    cycles++;
    if (!reset_n) begin
      exp0 = '0;
      exp1 = '0;
    end else begin
      exp0 = exp0 + ev_inc(sel0, sup);
      exp1 = exp1 + ev_inc(sel1, 1'b0);
    end
    exp_hold = reset_n & (|(wr & hit & own & ~walk & ~io));
    wb_stable = (wbuf_n == wbuf_last) ? wb_stable + 1 : 0;
    wbuf_last = wbuf_n;
    // a hung scenario ends here, counted as a mismatch
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // compare where the outputs are settled; hold only once the pin level has crossed the synchroniser
  always @(negedge mclk) begin
    if (cycles > 0) begin
      check(c0 === exp0, "counter0");
      check(c1 === exp1, "counter1");
      if (wb_stable > 4) begin
        check(hold === (exp_hold & wbuf_last), "write hold");
      end
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  initial begin
    addr[0] = '0;
    addr[1] = '0;
    cyc(2);
    reset_n <= 1'b1;
    // random traffic; noncacheable so no fill hides a miss
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk);
      if (i % 40 == 0) begin
        sel0 <= (i == 1200) ? 6'h3f : 6'($random(seed)) & 6'h07;
        sel1 <= 6'($random(seed)) & 6'h07;
      end
      if (i % 64 == 0) begin
        wbuf_n <= 1'($random(seed));
      end
      rd <= 2'($random(seed));
      wr <= 2'($random(seed));
      walk <= 2'($random(seed)) & 2'($random(seed));
      io <= 2'($random(seed)) & 2'($random(seed));
      hit <= 2'($random(seed));
      own <= 2'($random(seed));
      xlat <= 1'($random(seed));
      burst_ready_n_n <= 1'($random(seed));
      addr[0] <= PEC_LINE_W'($random(seed));
      addr[1] <= PEC_LINE_W'($random(seed));
    end
    @(posedge mclk);
    {rd, wr, walk, io, hit, own, xlat, burst_ready_n_n} <= {12'h000, 1'b0, 1'b1};
    sel0 <= PEC_EV_READ_MISS;
    sel1 <= PEC_EV_DATA_READ;
    $display("test random done");
    // line fill: a repeat miss to the line is hidden between the first and last beat
    cyc(6);
    rd <= 2'h1;
    cach <= 2'h1;
    addr[0] <= 27'h000_0a5a;
    @(posedge mclk);
    rd <= 2'h0;
    cach <= 2'h0;
    @(negedge mclk);
    check(fill === 1'b1, "fill start");
    // a repeat miss to the line before its first beat still counts
    @(posedge mclk);
    burst_ready_n_n <= 1'b0;
    rd <= 2'h1;
    @(posedge mclk);
    burst_ready_n_n <= 1'b1;
    rd <= 2'h0;
    cyc(4);
    rd <= 2'h3;
    sup <= 1'b1;
    addr[1] <= 27'h000_0b5b;
    @(posedge mclk);
    rd <= 2'h0;
    sup <= 1'b0;
    @(posedge mclk);
    burst_ready_n_n <= 1'b0;
    cyc(3);
    burst_ready_n_n <= 1'b1;
    cyc(6);
    @(negedge mclk);
    check(fill === 1'b0, "fill end");
    @(posedge mclk);
    rd <= 2'h1;
    @(posedge mclk);
    rd <= 2'h0;
    cyc(4);
    $display("test fill done");
    print_verdict();
  end
endmodule
